//--- rtl/ail_cfg.svh
`ifndef AIL_CFG_SVH
`define AIL_CFG_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define AIL_A_CTRL 8'h00
`define AIL_A_SYNC 8'h04
`define AIL_A_CGAIN 8'h08
`define AIL_A_IGAIN 8'h0C
`define AIL_A_RATIO 8'h10
`define AIL_A_REF 8'h14
`define AIL_A_WX 8'h18
`define AIL_A_WY 8'h1C
`define AIL_A_STAT 8'h20

// ----------------------------------------
// Field positions
// ----------------------------------------
`define AIL_B_COUPLE 0
`define AIL_B_REV 1
`define AIL_B_SEL 2
`define AIL_B_BUSY 16
`define AIL_B_USABLE 17
`define AIL_F_B0 7:0
`define AIL_F_B1 15:8
`define AIL_F_H0 15:0
`define AIL_F_H1 31:16

// ----------------------------------------
// Reset values
// ----------------------------------------
`define AIL_R_SYNC 8'h40
`define AIL_R_CGAIN 8'h80
`define AIL_R_IGAIN 8'h00
`define AIL_R_RATIO 8'h50
`define AIL_R_REF 8'h80
`define AIL_R_X0 16'h01E0
`define AIL_R_X1 16'h05A0
`define AIL_R_Y0 16'h010E
`define AIL_R_Y1 16'h032A

// ----------------------------------------
// Limits, scaling and timing
// ----------------------------------------
`define AIL_RATIO_MIN 8'h14
`define AIL_RATIO_MAX 8'hA0
`define AIL_LVL_MAX 8'hFF
`define AIL_REV_SH 8
`define AIL_CG_SH 7
`define AIL_INT_SH 20
`define AIL_HS_NS 4700
`define AIL_CLK_NS 4
`define AIL_OKAY 2'h0
`define AIL_SLVERR 2'h2

`endif

//--- rtl/ail_pkg.sv
package ail_pkg;

  typedef enum logic [1:0] {
    AIL_IRIS_VIDEO = 2'b00,
    AIL_IRIS_CLOSE = 2'b01,
    AIL_IRIS_OPEN = 2'b10
  } ail_iris_e;

  typedef enum logic [1:0] {
    AIL_EXP_CONT = 2'b00,
    AIL_EXP_PREDUMP = 2'b01,
    AIL_EXP_TRIG = 2'b10,
    AIL_EXP_OTHER = 2'b11
  } ail_exp_e;

  typedef enum logic [2:0] {
    AIL_ST_IDLE = 3'b000,
    AIL_ST_AVG = 3'b001,
    AIL_ST_REV = 3'b010,
    AIL_ST_GAIN = 3'b011
  } ail_state_e;

  typedef struct packed {
    logic couple;
    logic rev;
    ail_iris_e sel;
    logic [7:0] sync;
    logic [7:0] cgain;
    logic [7:0] igain;
    logic [7:0] ratio;
    logic [7:0] gref;
    logic [15:0] x0;
    logic [15:0] x1;
    logic [15:0] y0;
    logic [15:0] y1;
  } ail_cfg_s;

endpackage : ail_pkg

//--- rtl/ail_div.sv
`timescale 1ns/1ns
module ail_div #(
  parameter int W = 32
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Request
  input wire logic start,
  input wire logic [W-1:0] num,
  input wire logic [W-1:0] den,
  // Result
  output logic busy,
  output logic done,
  output logic [W-1:0] quo
);
  localparam int KW = $clog2(W + 1);
  logic [W-1:0] n_q;
  logic [W-1:0] d_q;
  logic [W:0] r_q;
  logic [KW-1:0] k_q;
  logic [W:0] r_sh;
  logic [W:0] trial;

  always_comb begin
    r_sh = {r_q[W-1:0], n_q[W-1]};
    trial = r_sh - {1'b0, d_q};
  end

  // Restoring division, one quotient bit per cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy <= 1'b0;
      done <= 1'b0;
      quo <= '0;
      n_q <= '0;
      d_q <= '0;
      r_q <= '0;
      k_q <= '0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        n_q <= num;
        d_q <= (den == '0) ? W'(1) : den;
        r_q <= '0;
        k_q <= KW'(W);
        busy <= 1'b1;
      end else if (busy) begin
        r_q <= trial[W] ? r_sh : trial;
        n_q <= {n_q[W-2:0], ~trial[W]};
        k_q <= k_q - KW'(1);
        if (k_q == KW'(1)) begin
          busy <= 1'b0;
          done <= 1'b1;
          quo <= {n_q[W-2:0], ~trial[W]};
        end
      end
    end
  end

endmodule : ail_div

//--- rtl/ail_top.sv
// Function
// RQ1: Per-frame centre average, held over frame
// RQ2: Composite output with sync on every line
// RQ3: Coupling joins iris to combined light control
// RQ4: Reverse gain divides by front-end gain
// RQ5: Selector: video, forced close, forced open
// RQ6: Eight-bit sync amplitude, 0 to 255
// RQ7: Separate control gain 0 to 255
// RQ8: Interpolation gain smooths levels between frames
// RQ9: Calculation ratio 20 to 160 scales interpolation
// RQ10: Interpolation relative to gain reference target
// RQ11: Output usable only continuous or pre-dump
// RQ12: Settings take effect at frame boundary
`timescale 1ns/1ns
`include "ail_cfg.svh"
module ail_top
  import ail_pkg::*;
#(
  parameter int AW = 8,
  parameter int PW = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Video timing and pixels
  input wire logic vid_fval,
  input wire logic vid_lval,
  input wire logic vid_dval,
  input wire logic [PW-1:0] vid_pix,
  // Camera state
  input wire logic [15:0] afe_gain,
  input wire ail_exp_e exp_mode,
  // Iris output
  output logic [7:0] iris_level,
  output logic [8:0] iris_video,
  output logic iris_usable,
  // Combined light control
  output logic alc_coupled,
  output logic signed [9:0] alc_iris_err
);

  localparam logic [10:0] HS_LOAD = 11'(`AIL_HS_NS / `AIL_CLK_NS);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic [31:0] wr_merge(input logic [31:0] o,
      input logic [31:0] d, input logic [3:0] s);
    wr_merge = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        wr_merge[8*i +: 8] = d[8*i +: 8];
      end
    end
  endfunction : wr_merge

  function automatic logic [7:0] clamp8(input logic signed [31:0] v);
    if (v < 0) begin
      clamp8 = 8'h00;
    end else if (v > $signed({24'h0, `AIL_LVL_MAX})) begin
      clamp8 = `AIL_LVL_MAX;
    end else begin
      clamp8 = v[7:0];
    end
  endfunction : clamp8

  function automatic logic is_map(input logic [AW-1:0] a);
    case (a)
      `AIL_A_CTRL, `AIL_A_SYNC, `AIL_A_CGAIN, `AIL_A_IGAIN,
      `AIL_A_RATIO, `AIL_A_REF, `AIL_A_WX, `AIL_A_WY,
      `AIL_A_STAT: is_map = 1'b1;
      default: is_map = 1'b0;
    endcase
  endfunction : is_map

  function automatic logic [31:0] rd_of(input logic [AW-1:0] a,
      input ail_cfg_s c, input logic [31:0] st);
    rd_of = 32'h0;
    case (a)
      `AIL_A_CTRL: begin
        rd_of[`AIL_B_COUPLE] = c.couple;
        rd_of[`AIL_B_REV] = c.rev;
        rd_of[`AIL_B_SEL +: 2] = c.sel;
      end
      `AIL_A_SYNC: rd_of[`AIL_F_B0] = c.sync;
      `AIL_A_CGAIN: rd_of[`AIL_F_B0] = c.cgain;
      `AIL_A_IGAIN: rd_of[`AIL_F_B0] = c.igain;
      `AIL_A_RATIO: rd_of[`AIL_F_B0] = c.ratio;
      `AIL_A_REF: rd_of[`AIL_F_B0] = c.gref;
      `AIL_A_WX: rd_of = {c.x1, c.x0};
      `AIL_A_WY: rd_of = {c.y1, c.y0};
      `AIL_A_STAT: rd_of = st;
      default: rd_of = 32'h0;
    endcase
  endfunction : rd_of

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  ail_cfg_s cfg_q;
  ail_cfg_s cfg_s_q;
  ail_state_e st_q;
  logic aw_have_q;
  logic w_have_q;
  logic [AW-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_go;
  logic [31:0] wd;
  logic [31:0] stat;
  logic fval_q;
  logic lval_q;
  logic f_rise;
  logic f_fall;
  logic l_rise;
  logic l_fall;
  logic [15:0] x_q;
  logic [15:0] y_q;
  logic in_win;
  logic [31:0] sum_q;
  logic [31:0] cnt_q;
  logic div_start;
  logic [31:0] div_num;
  logic [31:0] div_den;
  logic div_done;
  logic [31:0] div_quo;
  logic [7:0] quo8;
  logic [7:0] avg_q;
  logic [7:0] lvl_q;
  logic signed [31:0] dg;
  logic signed [9:0] tgt_q;
  logic signed [9:0] c_q;
  logic signed [10:0] diff;
  logic [15:0] k_int;
  logic signed [31:0] prod;
  logic signed [31:0] step;
  logic usable_q;
  logic tgt_upd_q;
  logic [10:0] hs_q;

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready = !w_have_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wd = wr_merge(rd_of(aw_addr_q, cfg_q, stat), w_data_q, w_strb_q);
  assign stat = {14'h0, usable_q, st_q != AIL_ST_IDLE, iris_level, avg_q};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AIL_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_map(aw_addr_q) ? `AIL_OKAY : `AIL_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `AIL_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_of(s_axi_araddr, cfg_q, stat);
      s_axi_rresp <= is_map(s_axi_araddr) ? `AIL_OKAY : `AIL_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Live settings, written by software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q <= '{couple: 1'b0, rev: 1'b0, sel: AIL_IRIS_VIDEO,
                 sync: `AIL_R_SYNC, cgain: `AIL_R_CGAIN,
                 igain: `AIL_R_IGAIN, ratio: `AIL_R_RATIO,
                 gref: `AIL_R_REF, x0: `AIL_R_X0, x1: `AIL_R_X1,
                 y0: `AIL_R_Y0, y1: `AIL_R_Y1};
    end else if (wr_go) begin
      case (aw_addr_q)
        `AIL_A_CTRL: begin
          cfg_q.couple <= wd[`AIL_B_COUPLE]; // [RQ3]
          cfg_q.rev <= wd[`AIL_B_REV]; // [RQ4]
          cfg_q.sel <= ail_iris_e'(wd[`AIL_B_SEL +: 2]); // [RQ5]
        end
        `AIL_A_SYNC: cfg_q.sync <= wd[`AIL_F_B0]; // [RQ6]
        `AIL_A_CGAIN: cfg_q.cgain <= wd[`AIL_F_B0]; // [RQ7]
        `AIL_A_IGAIN: cfg_q.igain <= wd[`AIL_F_B0]; // [RQ8]
        `AIL_A_RATIO: begin
          if (wd[`AIL_F_B0] < `AIL_RATIO_MIN) begin
            cfg_q.ratio <= `AIL_RATIO_MIN; // [RQ9]
          end else if (wd[`AIL_F_B0] > `AIL_RATIO_MAX) begin
            cfg_q.ratio <= `AIL_RATIO_MAX; // [RQ9]
          end else begin
            cfg_q.ratio <= wd[`AIL_F_B0];
          end
        end
        `AIL_A_REF: cfg_q.gref <= wd[`AIL_F_B0]; // [RQ10]
        `AIL_A_WX: begin
          cfg_q.x0 <= wd[`AIL_F_H0];
          cfg_q.x1 <= wd[`AIL_F_H1];
        end
        `AIL_A_WY: begin
          cfg_q.y0 <= wd[`AIL_F_H0];
          cfg_q.y1 <= wd[`AIL_F_H1];
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Frame timing and centre accumulation
  // ----------------------------------------
  assign f_rise = vid_fval && !fval_q;
  assign f_fall = !vid_fval && fval_q;
  assign l_rise = vid_lval && !lval_q;
  assign l_fall = !vid_lval && lval_q;
  assign in_win = x_q >= cfg_s_q.x0 && x_q < cfg_s_q.x1 &&
                  y_q >= cfg_s_q.y0 && y_q < cfg_s_q.y1;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fval_q <= 1'b0;
      lval_q <= 1'b0;
      cfg_s_q <= '0;
    end else begin
      fval_q <= vid_fval;
      lval_q <= vid_lval;
      if (f_rise) begin
        cfg_s_q <= cfg_q; // [RQ12]
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      x_q <= 16'h0;
      y_q <= 16'h0;
    end else begin
      x_q <= vid_lval ? x_q + 16'(vid_dval) : 16'h0;
      y_q <= f_rise ? 16'h0 : y_q + 16'(l_fall);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sum_q <= 32'h0;
      cnt_q <= 32'h0;
    end else if (f_rise) begin
      sum_q <= 32'h0;
      cnt_q <= 32'h0;
    end else if (vid_fval && vid_lval && vid_dval && in_win) begin
      sum_q <= sum_q + 32'(vid_pix); // [RQ1]
      cnt_q <= cnt_q + 32'h1;
    end
  end

  // ----------------------------------------
  // Frame-end calculation
  // ----------------------------------------
  assign quo8 = clamp8($signed(div_quo));
  assign div_start = (st_q == AIL_ST_IDLE && f_fall) ||
                     (st_q == AIL_ST_AVG && div_done && cfg_s_q.rev);
  assign div_num = (st_q == AIL_ST_IDLE) ? sum_q :
                   32'(quo8) << `AIL_REV_SH; // [RQ4]
  assign div_den = (st_q == AIL_ST_IDLE) ? cnt_q : 32'(afe_gain);
  assign dg = ($signed(32'(lvl_q)) - $signed(32'(cfg_s_q.gref))) *
              $signed(32'(cfg_s_q.cgain)) >>> `AIL_CG_SH; // [RQ7]

  ail_div #(
    .W(32)
  ) u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(div_start),
    .num(div_num),
    .den(div_den),
    .busy(),
    .done(div_done),
    .quo(div_quo)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= AIL_ST_IDLE;
      avg_q <= 8'h00;
      lvl_q <= 8'h00;
      tgt_q <= '0;
    end else begin
      case (st_q)
        AIL_ST_IDLE: begin
          if (f_fall) begin
            st_q <= AIL_ST_AVG;
          end
        end
        AIL_ST_AVG: begin
          if (div_done) begin
            avg_q <= quo8; // [RQ1]
            lvl_q <= quo8;
            st_q <= cfg_s_q.rev ? AIL_ST_REV : AIL_ST_GAIN; // [RQ4]
          end
        end
        AIL_ST_REV: begin
          if (div_done) begin
            lvl_q <= quo8; // [RQ4]
            st_q <= AIL_ST_GAIN;
          end
        end
        AIL_ST_GAIN: begin
          if (dg < -$signed(32'(`AIL_LVL_MAX))) begin
            tgt_q <= -$signed(10'(`AIL_LVL_MAX));
          end else if (dg > $signed(32'(`AIL_LVL_MAX))) begin
            tgt_q <= $signed(10'(`AIL_LVL_MAX));
          end else begin
            tgt_q <= dg[9:0]; // [RQ10]
          end
          st_q <= AIL_ST_IDLE;
        end
        default: st_q <= AIL_ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Interpolation between frames
  // ----------------------------------------
  always_comb begin
    diff = 11'(tgt_q) - 11'(c_q);
    k_int = 16'(cfg_s_q.igain) * 16'(cfg_s_q.ratio); // [RQ9]
    prod = $signed(32'(diff)) * $signed({16'h0, k_int});
    step = prod >>> `AIL_INT_SH;
    if (step == 0) begin
      step = (diff > 0) ? 32'sd1 : -32'sd1;
    end
  end

  // Target is written in the gain state, so take it one cycle later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tgt_upd_q <= 1'b0;
    end else begin
      tgt_upd_q <= st_q == AIL_ST_GAIN;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      c_q <= '0;
    end else if (cfg_s_q.igain == 8'h00) begin
      if (tgt_upd_q) begin
        c_q <= tgt_q; // [RQ1]
      end
    end else if (l_rise && c_q != tgt_q) begin
      c_q <= c_q + step[9:0]; // [RQ8]
    end
  end

  // ----------------------------------------
  // Composite iris output
  // ----------------------------------------
  assign iris_usable = usable_q;
  assign alc_coupled = cfg_s_q.couple;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      usable_q <= 1'b0;
      iris_level <= 8'h00;
      alc_iris_err <= '0;
    end else begin
      usable_q <= exp_mode == AIL_EXP_CONT ||
                  exp_mode == AIL_EXP_PREDUMP; // [RQ11]
      alc_iris_err <= cfg_s_q.couple ? c_q : 10'sd0; // [RQ3]
      if (usable_q) begin
        case (cfg_s_q.sel)
          AIL_IRIS_CLOSE: iris_level <= 8'h00; // [RQ5]
          AIL_IRIS_OPEN: iris_level <= `AIL_LVL_MAX; // [RQ5]
          default: iris_level <= clamp8($signed(32'(cfg_s_q.gref)) +
                                        $signed(32'(c_q))); // [RQ10]
        endcase
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hs_q <= 11'h0;
      iris_video <= 9'h000;
    end else begin
      hs_q <= l_rise ? HS_LOAD : hs_q - 11'(hs_q != 11'h0);
      iris_video <= (hs_q != 11'h0) ? 9'h000 :
                    {1'b0, cfg_s_q.sync} + {1'b0, iris_level}; // [RQ2]
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sync_tip_a: assert property (l_rise |-> ##2 iris_video == 9'h000) // [RQ2]
    else $error("no sync tip after line start");
  sync_amp_a: assert property (hs_q == 11'h0 |=> iris_video ==
      {1'b0, $past(cfg_s_q.sync)} + {1'b0, $past(iris_level)}) // [RQ6]
    else $error("video level not sync plus iris level");
  close_lvl_a: assert property (usable_q &&
      cfg_s_q.sel == AIL_IRIS_CLOSE |=> iris_level == 8'h00) // [RQ5]
    else $error("forced close level wrong");
  open_lvl_a: assert property (usable_q &&
      cfg_s_q.sel == AIL_IRIS_OPEN |=> iris_level == 8'hFF) // [RQ5]
    else $error("forced open level wrong");
  usable_hold_a: assert property (!iris_usable |=> $stable(iris_level))
    else $error("level changed while unusable"); // [RQ11]
  couple_off_a: assert property (!cfg_s_q.couple ##1 !cfg_s_q.couple
      |-> alc_iris_err == 10'sd0) // [RQ3]
    else $error("iris error leaked while uncoupled");
  shadow_hold_a: assert property (!f_rise |=> $stable(cfg_s_q)) // [RQ12]
    else $error("settings changed inside frame");
  ratio_rng_a: assert property (cfg_q.ratio >= 8'h14 &&
      cfg_q.ratio <= 8'hA0) // [RQ9]
    else $error("ratio out of range");
  rev_path_a: assert property (st_q == AIL_ST_AVG && div_done |=>
      st_q == (cfg_s_q.rev ? AIL_ST_REV : AIL_ST_GAIN)) // [RQ4]
    else $error("reverse gain step taken wrongly");
  frame_hold_a: assert property (cfg_s_q.igain == 8'h00 &&
      !tgt_upd_q |=> $stable(c_q)) // [RQ1]
    else $error("level moved inside frame");
  calc_time_a: assert property (st_q == AIL_ST_IDLE && f_fall |->
      ##[34:72] st_q == AIL_ST_GAIN) // [RQ1]
    else $error("frame calculation too slow");

  frame_end_c: cover property (f_fall ##[1:72] st_q == AIL_ST_GAIN);
  rev_c: cover property (st_q == AIL_ST_REV ##1 div_done);
  interp_c: cover property (l_rise && cfg_s_q.igain != 8'h00 &&
      c_q != tgt_q);
  close_c: cover property (usable_q && cfg_s_q.sel == AIL_IRIS_CLOSE);

endmodule : ail_top

//--- test/ail_lens_model.sv
`timescale 1ns/1ns
module ail_lens_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Composite iris video
  input wire logic [8:0] iris_video,
  // Observation
  output int sync_cnt
);
  logic [8:0] prev_q;
  // ----------------------------------------
  // Sync pulse detection
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_q <= '0;
      sync_cnt <= 0;
    end else begin
      prev_q <= iris_video;
      if (iris_video == 9'h000 && prev_q != 9'h000) begin
        sync_cnt <= sync_cnt + 1;
      end
    end
  end
endmodule : ail_lens_model

//--- test/ail_tb_top.sv
`timescale 1ns/1ns
`include "ail_cfg.svh"
module ail_tb_top;
  import ail_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = '0;
  logic [7:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic fval = 1'b0, lval = 1'b0, dval = 1'b0;
  logic [7:0] pix = '0;
  logic [15:0] afe_gain = 16'h0200;
  ail_exp_e exp_mode = AIL_EXP_CONT;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, rd;
  logic [7:0] iris_level;
  logic [8:0] iris_video;
  logic iris_usable, alc_coupled;
  logic signed [9:0] alc_iris_err;
  int err_count = 0, n_tests = 0, seed = 32'h6EFB;
  int sync_cnt, last_cnt = 0, lvl = 0, sum, hold = 128, vlvl = 128;
  int q[$];
  int ctl[6] = '{1, 3, 5, 9, 12, 0};

  ail_top DUT (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .vid_fval(fval), .vid_lval(lval), .vid_dval(dval), .vid_pix(pix),
    .afe_gain(afe_gain), .exp_mode(exp_mode), .iris_level(iris_level),
    .iris_video(iris_video), .iris_usable(iris_usable),
    .alc_coupled(alc_coupled), .alc_iris_err(alc_iris_err));

  ail_lens_model lens (.aclk(aclk), .aresetn(aresetn),
    .iris_video(iris_video), .sync_cnt(sync_cnt));

  // ----------------------------------------
  // Clock and watchdog
  // ----------------------------------------
  initial begin
    forever #2 aclk = ~aclk;
  end

  initial begin
    #(4 * 60000);
    err_count++;
    test_done();
  end

  // ----------------------------------------
  // Tasks and model
  // ----------------------------------------
  task automatic test_done();
    if (err_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  task automatic frame();
    int v;
    fval <= 1'b1;
    repeat (4) @(posedge aclk);
    for (int l = 0; l < 2; l++) begin
      for (int p = 0; p < 8; p++) begin
        v = $random(seed) & 255;
        pix <= v[7:0];
        lval <= 1'b1;
        dval <= 1'b1;
        if (p < 4) q.push_back(v);
        @(posedge aclk);
      end
      lval <= 1'b0;
      dval <= 1'b0;
      check(iris_video, 0);
      check(iris_level, hold);
      repeat (1190) @(posedge aclk);
    end
    fval <= 1'b0;
  endtask : frame

  function automatic int exp_level(input int c, input int avg);
    int a;
    a = avg;
    if (c[1]) a = a * 256 / 512;
    a = 128 + (((a - 128) * 128) >>> 7);
    if (a > 255) a = 255;
    if (a < 0) a = 0;
    if (c[3:2] == 2'b01) a = 0;
    if (c[3:2] == 2'b10) a = 255;
    return a;
  endfunction : exp_level

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`AIL_A_SYNC);
    check(rd, 32'h0000_0040);
    axi_rd(8'h24);
    check(rsp, `AIL_SLVERR);
    axi_wr(8'h24, 32'h0000_0001);
    check(rsp, `AIL_SLVERR);
    axi_wr(`AIL_A_RATIO, 32'h0000_00FF);
    axi_rd(`AIL_A_RATIO);
    check(rd, 32'h0000_00A0);
    axi_wr(`AIL_A_RATIO, 32'h0000_0005);
    axi_rd(`AIL_A_RATIO);
    check(rd, 32'h0000_0014);
    axi_wr(`AIL_A_SYNC, 32'h0000_0030);
    axi_wr(`AIL_A_WX, 32'h0004_0000);
    axi_wr(`AIL_A_WY, 32'h0002_0000);
    axi_wr(`AIL_A_CTRL, ctl[0]);
    for (int i = 1; i < 6; i++) begin
      hold = (ctl[i-1][3:2] == 2'b01) ? 0 :
             (ctl[i-1][3:2] == 2'b10) ? 255 : vlvl;
      fork
        frame();
        begin
          repeat (30) @(posedge aclk);
          axi_wr(`AIL_A_CTRL, ctl[i]);
        end
      join
      sum = 0;
      foreach (q[k]) sum += q[k];
      q.delete();
      repeat (100) @(posedge aclk);
      lvl = exp_level(ctl[i-1], sum / 8);
      vlvl = exp_level(ctl[i-1] & 3, sum / 8);
      check(iris_level, lvl);
      check(iris_video, 9'h030 + lvl);
      check(sync_cnt - last_cnt, 2);
      last_cnt = sync_cnt;
      check(alc_coupled, ctl[i-1] & 1);
      check(32'(alc_iris_err), (ctl[i-1] & 1) ? vlvl - 128 : 0);
      axi_rd(`AIL_A_STAT);
      check(rd[17:8], {2'b10, lvl[7:0]});
    end
    for (int m = 3; m >= 0; m--) begin
      exp_mode <= ail_exp_e'(m);
      repeat (2) @(posedge aclk);
      check(iris_usable, m < 2);
    end
    exp_mode <= AIL_EXP_TRIG;
    hold = lvl;
    frame();
    q.delete();
    repeat (100) @(posedge aclk);
    check(iris_level, lvl);
    test_done();
  end
endmodule : ail_tb_top
